// file: rtl/image_sensor_pixel_port.v
// pixel output port of the colour sensor: frame start, line valid, pixel bus
// assumes ref_clk is the master clock and adc_sample carries digitised pixels
//
// Summary of operation
// - enable high runs normally; enable low freezes all sensor timing
// - all timing runs from ref_clk; host keeps it at or under 20 MHz
// - reset input low means reset asserted, high means released
// - frame-start pulses at each frame start, its length programmable
// - line-valid high only while pixel bus is valid; blanking programmable
// - pixel is eight bits, bit 7 most and bit 0 least significant
// - host clocks the two-wire bus; device is target, pulls data low
// - gate option makes line-valid the AND of inverted pixel clock and valid
// - outputs change after the rising clock edge; host samples on falling
`timescale 1ns/1ps
`include "sensor_defs.vh"

module image_sensor_pixel_port (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       sensor_enable,
  input  wire [7:0] adc_sample,
  output reg  [7:0] pixel_bus,
  output reg        frame_start,
  output wire       line_valid_out,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n
);

  localparam [2:0] ST_FRAME  = 3'b001;
  localparam [2:0] ST_HBLANK = 3'b010;
  localparam [2:0] ST_ACTIVE = 3'b100;

  // ------------------------------------------------------------
  // configuration state
  // ------------------------------------------------------------
  reg  [7:0]          mode;
  reg  [`BLANK_W-1:0] h_blank;
  reg  [`BLANK_W-1:0] v_blank;
  reg  [7:0]          rd_data;
  wire                wr_en;
  wire [7:0]          reg_index;
  wire [7:0]          wr_data;

  // ------------------------------------------------------------
  // timing state
  // ------------------------------------------------------------
  reg  [2:0]          state;
  reg  [2:0]          next_state;
  reg  [`BLANK_W-1:0] cnt;
  reg  [`BLANK_W-1:0] next_cnt;
  reg  [`GEOM_W-1:0]  col;
  reg  [`GEOM_W-1:0]  next_col;
  reg  [`GEOM_W-1:0]  row;
  reg  [`GEOM_W-1:0]  next_row;
  reg                 pclk;
  reg                 data_valid;
  wire                tick;

  // true on the last count of a blanking span; zero length acts as one
  function last_count;
    input [`BLANK_W-1:0] count;
    input [`BLANK_W-1:0] limit;
    begin
      last_count = (limit == {`BLANK_W{1'b0}}) || (count >= limit - 16'h0001);
    end
  endfunction

  serial_cfg_target u_cfg (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe_n  (sda_oe_n),
    .wr_en     (wr_en),
    .reg_index (reg_index),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  // ------------------------------------------------------------
  // register writes; config survives enable low so setup can precede run
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      mode    <= `MODE_RESET;
      h_blank <= `HBLANK_RESET;
      v_blank <= `VBLANK_RESET;
    end else if (wr_en) begin
      case (reg_index)
        `IDX_MODE:      mode          <= wr_data;
        `IDX_HBLANK_HI: h_blank[15:8] <= wr_data;
        `IDX_HBLANK_LO: h_blank[7:0]  <= wr_data;
        `IDX_VBLANK_HI: v_blank[15:8] <= wr_data;
        `IDX_VBLANK_LO: v_blank[7:0]  <= wr_data;
        default:        mode          <= mode;
      endcase
    end
  end

  // read mux; unknown indices read zero
  always @* begin
    case (reg_index)
      `IDX_MODE:      rd_data = mode;
      `IDX_HBLANK_HI: rd_data = h_blank[15:8];
      `IDX_HBLANK_LO: rd_data = h_blank[7:0];
      `IDX_VBLANK_HI: rd_data = v_blank[15:8];
      `IDX_VBLANK_LO: rd_data = v_blank[7:0];
      default:        rd_data = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // internal pixel clock: half of ref_clk, stalled when disabled
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      pclk <= 1'b0;
    end else if (sensor_enable) begin
      pclk <= ~pclk;
    end
  end

  // a pixel step happens once per internal pixel clock period
  assign tick = sensor_enable & pclk;

  // ------------------------------------------------------------
  // frame sequencer: frame blank, then line blank and active per row
  // ------------------------------------------------------------
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    next_col   = col;
    next_row   = row;
    if (tick) begin
      case (state)
        ST_FRAME: begin
          next_cnt = cnt + 16'h0001;
          if (last_count(cnt, v_blank)) begin
            next_state = ST_HBLANK;
            next_cnt   = {`BLANK_W{1'b0}};
            next_row   = {`GEOM_W{1'b0}};
          end
        end
        ST_HBLANK: begin
          next_cnt = cnt + 16'h0001;
          if (last_count(cnt, h_blank)) begin
            next_state = ST_ACTIVE;
            next_cnt   = {`BLANK_W{1'b0}};
            next_col   = {`GEOM_W{1'b0}};
          end
        end
        ST_ACTIVE: begin
          next_col = col + 9'd1;
          if (col == `FRAME_WIDTH - 9'd1) begin
            next_row = row + 9'd1;
            if (row == `FRAME_HEIGHT - 9'd1) begin
              next_state = ST_FRAME;
            end else begin
              next_state = ST_HBLANK;
            end
          end
        end
        default: next_state = ST_FRAME;
      endcase
    end
  end

  // state and outputs all move on the rising edge
  always @(posedge ref_clk) begin
    if (!resetn) begin
      // park on the last pixel so the first step opens a full-length frame blank
      state       <= ST_ACTIVE;
      cnt         <= {`BLANK_W{1'b0}};
      col         <= `FRAME_WIDTH - 9'd1;
      row         <= `FRAME_HEIGHT - 9'd1;
      frame_start <= 1'b0;
      data_valid  <= 1'b0;
      pixel_bus   <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      col   <= next_col;
      row   <= next_row;
      if (tick) begin
        frame_start <= (next_state == ST_FRAME);
        data_valid  <= (next_state == ST_ACTIVE);
        // bus holds the last pixel during blanking; only valid-flagged data counts
        if (next_state == ST_ACTIVE) begin
          pixel_bus <= adc_sample;
        end
      end
    end
  end

  // gated form doubles as a strobe: high in the first half of each pixel
  assign line_valid_out = mode[`MODE_GATE_BIT] ? (data_valid & ~pclk) : data_valid;

endmodule // image_sensor_pixel_port

// file: inc/sensor_defs.vh
// constants shared by the pixel port and its serial configuration target
// assumes a 20 MHz reference clock and a byte-wide register space
`ifndef SENSOR_DEFS_VH
`define SENSOR_DEFS_VH

// ------------------------------------------------------------
// frame geometry
// ------------------------------------------------------------
`define FRAME_WIDTH       9'd400
`define FRAME_HEIGHT      9'd300
`define GEOM_W            9

// ------------------------------------------------------------
// configuration register indices and fields
// ------------------------------------------------------------
`define IDX_MODE          8'h01
`define IDX_HBLANK_HI     8'h20
`define IDX_HBLANK_LO     8'h21
`define IDX_VBLANK_HI     8'h22
`define IDX_VBLANK_LO     8'h23
`define MODE_RESET        8'h04
`define MODE_GATE_BIT     3
`define HBLANK_RESET      16'h0010
`define VBLANK_RESET      16'h0004
`define BLANK_W           16

// ------------------------------------------------------------
// serial target
// ------------------------------------------------------------
`define TARGET_ADDR       7'h21
`define BIT_LAST          3'd7
`define BYTE_W            8

`endif

// file: rtl/serial_cfg_target.v
// two-wire configuration target: address, register index, data bytes
// assumes scl/sda are sampled on ref_clk, far slower than the clock
`timescale 1ns/1ps
`include "sensor_defs.vh"

module serial_cfg_target (
  input  wire       ref_clk,
  input  wire       resetn,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output reg        sda_oe_n,
  output reg        wr_en,
  output reg  [7:0] reg_index,
  output reg  [7:0] wr_data,
  input  wire [7:0] rd_data
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_ACK  = 5'h04;
  localparam [4:0] ST_RX   = 5'h08;
  localparam [4:0] ST_TX   = 5'h10;

  reg [4:0] state;
  reg       scl_d;
  reg       sda_d;
  reg [2:0] bit_cnt;
  reg [7:0] shift;
  reg       is_read;
  reg       have_index;
  reg       ack_owed;
  reg       tx_lead;

  wire scl_rise = scl_in & ~scl_d;
  wire scl_fall = ~scl_in & scl_d;
  wire start_c  = scl_in & scl_d & sda_d & ~sda_in;
  wire stop_c   = scl_in & scl_d & ~sda_d & sda_in;

  // the pad is only ever pulled low; release lets the bus pull-up win
  assign sda_out = 1'b0;

  // ------------------------------------------------------------
  // bit engine: shift in on scl rise, drive on scl fall
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    scl_d <= scl_in;
    sda_d <= sda_in;
    wr_en <= 1'b0;
    if (!resetn) begin
      state      <= ST_IDLE;
      sda_oe_n   <= 1'b1;
      bit_cnt    <= 3'd0;
      shift      <= 8'h00;
      is_read    <= 1'b0;
      have_index <= 1'b0;
      ack_owed   <= 1'b0;
      tx_lead    <= 1'b0;
      reg_index  <= 8'h00;
      wr_data    <= 8'h00;
    end else if (start_c) begin
      state      <= ST_ADDR;
      bit_cnt    <= 3'd0;
      have_index <= 1'b0;
      sda_oe_n   <= 1'b1;
    end else if (stop_c) begin
      state    <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: sda_oe_n <= 1'b1;
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_in};
            bit_cnt <= bit_cnt + 3'd1;
            if (bit_cnt == `BIT_LAST) begin
              state <= ST_ACK;
              if (state == ST_ADDR) begin
                ack_owed <= (shift[6:0] == `TARGET_ADDR);
                is_read  <= sda_in;
              end else begin
                ack_owed <= 1'b1;
                if (have_index) begin
                  wr_en     <= 1'b1;
                  wr_data   <= {shift[6:0], sda_in};
                end else begin
                  reg_index  <= {shift[6:0], sda_in};
                  have_index <= 1'b1;
                end
              end
            end
          end
        end
        ST_ACK: begin
          // acknowledge slot: pull low during the ninth clock
          if (scl_fall) begin
            if (sda_oe_n) begin
              sda_oe_n <= ~ack_owed;
              if (!ack_owed) state <= ST_IDLE;
            end else begin
              sda_oe_n <= 1'b1;
              bit_cnt  <= 3'd0;
              if (is_read) begin
                state    <= ST_TX;
                shift    <= rd_data;
                sda_oe_n <= rd_data[7];
              end else begin
                state <= ST_RX;
              end
              if (have_index && wr_en == 1'b0 && is_read == 1'b0) reg_index <= reg_index;
            end
          end
          if (wr_en) reg_index <= reg_index + 8'h01;
        end
        ST_TX: begin
          if (scl_fall) begin
            if (tx_lead) begin
              // follow-on byte: its top bit goes out on the first fall
              tx_lead  <= 1'b0;
              sda_oe_n <= shift[7];
            end else if (bit_cnt == `BIT_LAST) begin
              // release for the master ack bit, then the next byte
              sda_oe_n  <= 1'b1;
              reg_index <= reg_index + 8'h01;
              state     <= ST_RX;
              bit_cnt   <= 3'd0;
              ack_owed  <= 1'b0;
            end else begin
              bit_cnt  <= bit_cnt + 3'd1;
              shift    <= {shift[6:0], 1'b0};
              sda_oe_n <= shift[6];
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      // master ack after a read byte: nack ends, ack sends the next byte
      if (state == ST_RX && is_read && scl_rise) begin
        if (sda_in) state <= ST_IDLE;
        else begin
          state    <= ST_TX;
          shift    <= rd_data;
          bit_cnt  <= 3'd0;
          tx_lead  <= 1'b1;
        end
      end
    end
  end

endmodule // serial_cfg_target

// file: testbench/pixel_port_sva.sv
// checker for the pixel port: reset, stall, stepping, ack phase
// assumes it is bound to the pixel port top and sees its ports only
`timescale 1ns/1ps

module pixel_port_sva (
  input wire       ref_clk,
  input wire       resetn,
  input wire       sensor_enable,
  input wire [7:0] adc_sample,
  input wire [7:0] pixel_bus,
  input wire       frame_start,
  input wire       line_valid_out,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_out,
  input wire       sda_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // output relations
  // ----------------------------------------
  a_reset_clear: assert property (disable iff (1'b0) !resetn |=>
    pixel_bus == 8'h00 && !frame_start && !line_valid_out && sda_oe_n) else $error("reset state wrong");
  a_enable_freeze: assert property (!sensor_enable |=>
    $stable(pixel_bus) && $stable(frame_start) && $stable(line_valid_out)) else $error("moved while stalled");
  a_step_hold: assert property ($changed({pixel_bus, frame_start}) |=>
    $stable({pixel_bus, frame_start})) else $error("step shorter than two clocks");
  a_frame_min: assert property ($rose(frame_start) |-> frame_start[*2]) else $error("frame pulse short");
  a_valid_excl: assert property (frame_start |-> !line_valid_out) else $error("valid during frame");
  a_bus_valid: assert property ($changed(pixel_bus) |-> ##[0:1] line_valid_out)
    else $error("bus moved outside valid");
  a_start_enabled: assert property ($rose(frame_start) |-> $past(sensor_enable))
    else $error("frame began while stalled");
  // releasing the data line while the clock is high would look like a stop
  a_sda_release: assert property ($rose(sda_oe_n) |-> !scl_in) else $error("release not in clock low");
  a_ack_phase: assert property ($fell(sda_oe_n) |-> !scl_in) else $error("ack not in clock low");

  c_frame: cover property ($rose(frame_start));
  c_line: cover property ($fell(line_valid_out));
  c_ack: cover property ($fell(sda_oe_n));
endmodule // pixel_port_sva

bind image_sensor_pixel_port pixel_port_sva u_pixel_port_sva (.ref_clk, .resetn, .sensor_enable,
  .adc_sample, .pixel_bus, .frame_start, .line_valid_out, .scl_in, .sda_in, .sda_out, .sda_oe_n);

// file: testbench/host_capture_model.sv
// host side: capture on falling edge plus a two-wire write master
// assumes sda has a pull-up and scl idles high between transfers
`timescale 1ns/1ps
`include "sensor_defs.vh"

module host_capture_model (
  input  wire        ref_clk,
  input  wire [7:0]  pixel_bus,
  input  wire        frame_start,
  input  wire        line_valid_out,
  input  wire        sda_out,
  input  wire        sda_oe_n,
  output reg         scl_in,
  output wire        sda_in,
  output reg  [15:0] last_run,
  output reg  [15:0] fs_run,
  output reg  [7:0]  last_pix
);
  reg        host_sda = 1'b1;
  reg [15:0] run = 16'h0000;
  reg [15:0] fcnt = 16'h0000;

  // wired-and with pull-up, so a released line reads high
  assign sda_in = host_sda & (sda_oe_n | sda_out);

  initial begin
    scl_in = 1'b1;
    last_run = 16'h0000;
    fs_run = 16'h0000;
    last_pix = 8'h00;
  end

  // falling edge capture: outputs have settled after the rising edge
  always @(negedge ref_clk) begin
    if (line_valid_out) begin
      run <= run + 16'h0001;
      last_pix <= pixel_bus;
    end else if (run != 16'h0000) begin
      last_run <= run;
      run <= 16'h0000;
    end
    if (frame_start) fcnt <= fcnt + 16'h0001;
    else if (fcnt != 16'h0000) begin
      fs_run <= fcnt;
      fcnt <= 16'h0000;
    end
  end

  task half(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask

  // data changes only mid-way through scl low, host clocks the bus
  task put_byte(input [7:0] b, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        half(5);
        host_sda = b[i];
        half(5);
        scl_in = 1'b1;
        half(10);
        scl_in = 1'b0;
      end
      half(5);
      host_sda = 1'b1;
      half(5);
      scl_in = 1'b1;
      half(5);
      ack = ~sda_in;
      half(5);
      scl_in = 1'b0;
    end
  endtask

  task write_reg(input [7:0] idx, input [7:0] val, output [2:0] acks);
    begin
      host_sda = 1'b0;
      half(10);
      scl_in = 1'b0;
      put_byte({`TARGET_ADDR, 1'b0}, acks[2]);
      put_byte(idx, acks[1]);
      put_byte(val, acks[0]);
      half(5);
      host_sda = 1'b0;
      half(5);
      scl_in = 1'b1;
      half(10);
      host_sda = 1'b1;
      half(10);
    end
  endtask
endmodule // host_capture_model

// file: testbench/image_sensor_pixel_port_bench.sv
// bench for the pixel port: reset, frame, stall, gated valid
// assumes the host model drives the two-wire pins
`timescale 1ns/1ps
`include "sensor_defs.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin failures = failures + 1; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module image_sensor_pixel_port_bench;
  reg         ref_clk = 1'b0;
  reg         resetn = 1'b0;
  reg         sensor_enable = 1'b1;
  reg  [7:0]  adc_sample = 8'hc1;
  reg  [8:0]  snap;
  reg  [2:0]  acks;
  wire [7:0]  pixel_bus, last_pix;
  wire [15:0] last_run, fs_run;
  wire        frame_start, line_valid_out, scl_in, sda_in, sda_out, sda_oe_n;
  integer     failures = 0, n_checks = 0, cycles = 0, n, g;

  image_sensor_pixel_port u_image_sensor_pixel_port (.ref_clk, .resetn, .sensor_enable, .adc_sample,
    .pixel_bus, .frame_start, .line_valid_out, .scl_in, .sda_in, .sda_out, .sda_oe_n);
  host_capture_model u_host_capture_model (.ref_clk, .pixel_bus, .frame_start, .line_valid_out,
    .sda_out, .sda_oe_n, .scl_in, .sda_in, .last_run, .fs_run, .last_pix);

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask

  // bounded wait on frame start (sel 1) or line valid (sel 0)
  task wait_on(input sel, input v);
    begin
      g = 0;
      while ((sel ? frame_start : line_valid_out) !== v && g < 3000) begin
        @(negedge ref_clk);
        g = g + 1;
      end
      // a wait that runs out counts as a mismatch
      if (g >= 3000) failures = failures + 1;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      repeat (20) @(negedge ref_clk);
      `CHK({pixel_bus, frame_start, line_valid_out, sda_oe_n}, 11'h001);
      resetn = 1'b1;
    end
  endtask

  task t_frame;
    begin
      wait_on(1, 1'b1);
      wait_on(1, 1'b0);
      @(negedge ref_clk);
      `CHK(fs_run, 2 * `VBLANK_RESET);
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      @(negedge ref_clk);
      `CHK(last_run, 2 * `FRAME_WIDTH);
      `CHK(last_pix, 8'hc1);
    end
  endtask

  // stall mid-line with a new sample waiting: nothing may move
  task t_stall;
    begin
      wait_on(0, 1'b1);
      repeat (11) @(negedge ref_clk);
      snap = {pixel_bus, line_valid_out};
      adc_sample = 8'h3e;
      sensor_enable = 1'b0;
      repeat (6) begin
        @(negedge ref_clk);
        `CHK({pixel_bus, line_valid_out}, snap);
      end
      sensor_enable = 1'b1;
      wait_on(0, 1'b0);
      @(negedge ref_clk);
      `CHK(last_run, 2 * `FRAME_WIDTH + 6);
      `CHK(last_pix, 8'h3e);
    end
  endtask

  // shorter line blank: the next gap between lines follows the new length
  task t_blank;
    begin
      u_host_capture_model.write_reg(`IDX_HBLANK_LO, 8'h05, acks);
      `CHK(acks, 3'b111);
      wait_on(0, 1'b1);
      wait_on(0, 1'b0);
      n = 0;
      while (line_valid_out === 1'b0 && n < 3000) begin
        n = n + 1;
        @(negedge ref_clk);
      end
      `CHK(n, 2 * 8'h05);
    end
  endtask

  task t_gate;
    begin
      u_host_capture_model.write_reg(`IDX_MODE, `MODE_RESET | (8'h01 << `MODE_GATE_BIT), acks);
      `CHK(acks, 3'b111);
      n = 0;
      g = 0;
      while (n < 10 && g < 3000) begin
        @(negedge ref_clk);
        g = g + 1;
        n = line_valid_out ? 0 : n + 1;
      end
      if (g >= 3000) failures = failures + 1;
      wait_on(0, 1'b1);
      n = 0;
      repeat (800) begin
        if (line_valid_out) n = n + 1;
        @(negedge ref_clk);
      end
      `CHK(n, `FRAME_WIDTH);
    end
  endtask

  // hang guard, well above the few lines the scenarios need
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 12000) begin
      failures = failures + 1;
      finish_test;
    end
  end

  initial begin
    t_reset;
    t_frame;
    t_stall;
    t_blank;
    t_gate;
    finish_test;
  end
endmodule // image_sensor_pixel_port_bench
